//--- hdl/scpr_top.v
`timescale 1ns/1ps
`include "scpr_defs.vh"
// Summary of operation
// - Our cascade enable output feeds the next memory's chip select.
// - Ready indicator pulled Low during power-on reset, then released.
// - Clock after final bit drives cascade enable Low, data driver off.
// - Chip select Low enables our data output, streaming our own contents.
// - Reset/output-enable Low after configuration clears the address counter.
// - Program-mode select Low enters 2-wire programming mode.
// - Program select High and chip select High gives standby, data floated.
// - Paging splits address space into four quarters, else full range.
// - Reset/output-enable Low clears counters; High with select Low drives data.
// - Stream counters advance only with select Low and enable High; with select High they freeze while prefetch fills the buffer.
// - Cascade output High until the range is spent, then follows select until enable falls.
module scpr_top (
	input wire mclk_i,
	input wire nrst_i,
	input wire fpga_config_clock_i,
	input wire chip_select_n_i,
	input wire reset_oe_i,
	input wire program_mode_n_i,
	input wire paging_enable_i,
	input wire [`SCPR_PICK_W-1:0] partition_pick_i,
	input wire [`SCPR_WORD_W-1:0] array_word_i,
	input wire array_valid_i,
	output wire array_req_o,
	output wire [`SCPR_ADDR_W-1:0] array_addr_o,
	output wire data_o,
	output wire data_oe_o,
	output wire cascade_enable_out_n_o,
	output wire ready_o,
	output wire ready_oe_o,
	output wire prog_mode_o,
	output wire standby_o
);
	reg clk_prev_reg;
	reg [`SCPR_ADDR_W-1:0] addr_reg;
	reg [`SCPR_ADDR_W-1:0] addr_next;
	reg [`SCPR_BIT_W-1:0] bit_reg;
	reg [`SCPR_BIT_W-1:0] bit_next;
	reg done_reg;
	reg done_next;
	reg [`SCPR_ADDR_W-1:0] fetch_addr_reg;
	reg [`SCPR_ADDR_W-1:0] fetch_addr_next;
	reg fetch_done_reg;
	reg fetch_done_next;
	reg req_reg;
	reg req_next;
	reg data_reg;
	reg data_oe_reg;
	reg cascade_n_reg;
	reg cascade_n_next;
	wire por_done;
	wire cfg_mode;
	wire clk_rise;
	wire clear;
	wire active;
	wire advance;
	wire last_bit;
	wire [`SCPR_ADDR_W-1:0] range_first;
	wire [`SCPR_ADDR_W-1:0] range_last;
	wire fifo_in_valid;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [`SCPR_WORD_W-1:0] fifo_head;
	wire [`SCPR_WORD_W-1:0] head_shifted;

	scpr_por u_por (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.por_done_o(por_done)
	);

	// Open collector: only ever drives Low
	assign ready_o = 1'b0;
	assign ready_oe_o = ~por_done;

	// Program-mode select Low hands the pins to the 2-wire programming port
	assign cfg_mode = program_mode_n_i;
	assign prog_mode_o = ~program_mode_n_i;
	assign standby_o = cfg_mode & chip_select_n_i;

	// Clock input is synchronous, so a plain previous-value compare suffices
	assign clk_rise = fpga_config_clock_i & ~clk_prev_reg;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			clk_prev_reg <= 1'b0;
		else
			clk_prev_reg <= fpga_config_clock_i;
	end

	// Quarter pages when partitioned, whole array otherwise
	assign range_first = paging_enable_i ? {partition_pick_i, `SCPR_PAGE_OFFSET_FIRST} : `SCPR_FULL_FIRST;
	assign range_last = paging_enable_i ? {partition_pick_i, `SCPR_PAGE_OFFSET_LAST} : `SCPR_FULL_LAST;

	// Counters held clear until power-on reset ends and while enable is Low
	assign clear = ~por_done | ~cfg_mode | ~reset_oe_i;
	assign active = ~clear & ~chip_select_n_i;
	// A missing prefetched word stalls the stream rather than sending garbage
	assign advance = active & clk_rise & ~done_reg & fifo_out_valid;
	assign last_bit = (bit_reg == `SCPR_BIT_LAST);
	assign fifo_out_ready = advance & last_bit;

	always @* begin
		addr_next = addr_reg;
		bit_next = bit_reg;
		done_next = done_reg;
		if (clear) begin
			addr_next = range_first;
			bit_next = `SCPR_BIT_FIRST;
			done_next = 1'b0;
		end else if (advance) begin
			bit_next = bit_reg + 4'h1;
			if (last_bit) begin
				if (addr_reg == range_last)
					done_next = 1'b1;
				else
					addr_next = addr_reg + 20'h00001;
			end
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_reg <= `SCPR_FULL_FIRST;
			bit_reg <= `SCPR_BIT_FIRST;
			done_reg <= 1'b0;
		end else begin
			addr_reg <= addr_next;
			bit_reg <= bit_next;
			done_reg <= done_next;
		end
	end

	// Prefetch runs ahead of the serial stream, stopped by a full buffer
	always @* begin
		fetch_addr_next = fetch_addr_reg;
		fetch_done_next = fetch_done_reg;
		req_next = req_reg;
		if (clear) begin
			fetch_addr_next = range_first;
			fetch_done_next = 1'b0;
			req_next = 1'b0;
		end else if (req_reg) begin
			if (array_valid_i) begin
				req_next = 1'b0;
				if (fetch_addr_reg == range_last)
					fetch_done_next = 1'b1;
				else
					fetch_addr_next = fetch_addr_reg + 20'h00001;
			end
		end else if (!fetch_done_reg && fifo_in_ready) begin
			req_next = 1'b1;
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fetch_addr_reg <= `SCPR_FULL_FIRST;
			fetch_done_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			fetch_addr_reg <= fetch_addr_next;
			fetch_done_reg <= fetch_done_next;
			req_reg <= req_next;
		end
	end

	assign array_req_o = req_reg;
	assign array_addr_o = fetch_addr_reg;
	// Words arriving after a clear belong to a dropped request
	assign fifo_in_valid = req_reg & array_valid_i & ~clear;

	scpr_fifo #(
		.WIDTH(`SCPR_WORD_W),
		.DEPTH(`SCPR_FIFO_DEPTH),
		.PTR_W(`SCPR_FIFO_PTR_W)
	) u_fifo (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.flush_i(clear),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(array_word_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_head)
	);

	// Most significant bit of each word goes out first
	assign head_shifted = fifo_head << bit_reg;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_reg <= 1'b0;
			data_oe_reg <= 1'b0;
		end else begin
			data_reg <= head_shifted[`SCPR_WORD_W-1];
			// Floated in standby, after the last bit, and when the enable is Low
			data_oe_reg <= active & ~done_next & fifo_out_valid;
		end
	end

	assign data_o = data_reg;
	assign data_oe_o = data_oe_reg;

	// Once the range is spent the output tracks chip select; enable Low re-arms
	always @* begin
		cascade_n_next = 1'b1;
		if (!clear && done_next)
			cascade_n_next = chip_select_n_i;
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			cascade_n_reg <= 1'b1;
		else
			cascade_n_reg <= cascade_n_next;
	end

	assign cascade_enable_out_n_o = cascade_n_reg;
endmodule // scpr_top

//--- hdl/scpr_defs.vh
`ifndef SCPR_DEFS_VH
`define SCPR_DEFS_VH
// Array geometry: 1M words of 16 bits, read MSB first
`define SCPR_ADDR_W 20
`define SCPR_WORD_W 16
`define SCPR_BIT_W 4
`define SCPR_BIT_LAST 4'hf
`define SCPR_BIT_FIRST 4'h0
// Partitioning
`define SCPR_PICK_W 2
`define SCPR_PAGE_LSB 18
`define SCPR_PAGE_OFFSET_W 18
`define SCPR_PAGE_OFFSET_LAST 18'h3ffff
`define SCPR_PAGE_OFFSET_FIRST 18'h00000
`define SCPR_FULL_FIRST 20'h00000
`define SCPR_FULL_LAST 20'hfffff
// Prefetch buffer
`define SCPR_FIFO_DEPTH 4
`define SCPR_FIFO_PTR_W 2
// Power-on reset cycle
`define SCPR_CLK_PERIOD_NS 4
`define SCPR_POR_TIME_NS 1000
`define SCPR_POR_CYCLES ((`SCPR_POR_TIME_NS + `SCPR_CLK_PERIOD_NS - 1) / `SCPR_CLK_PERIOD_NS)
`define SCPR_POR_CNT_W 9
`define SCPR_POR_CNT_RESET 9'h000
`endif

//--- hdl/scpr_fifo.v
`timescale 1ns/1ps
module scpr_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter PTR_W = 2
) (
	input wire mclk_i,
	input wire nrst_i,
	input wire flush_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_reg;
	reg [PTR_W-1:0] rd_ptr_reg;
	reg [PTR_W:0] count_reg;
	wire push;
	wire pop;
	integer i;

	assign in_ready_o = (count_reg != DEPTH[PTR_W:0]);
	assign out_valid_o = (count_reg != {(PTR_W+1){1'b0}});
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i & in_ready_o & ~flush_i;
	assign pop = out_valid_o & out_ready_i & ~flush_i;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg <= {(PTR_W+1){1'b0}};
		end else if (flush_i) begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg <= {(PTR_W+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_reg[i] <= {WIDTH{1'b0}};
		end else if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end
endmodule // scpr_fifo

//--- hdl/scpr_por.v
`timescale 1ns/1ps
`include "scpr_defs.vh"
module scpr_por (
	input wire mclk_i,
	input wire nrst_i,
	output wire por_done_o
);
	reg [`SCPR_POR_CNT_W-1:0] cnt_reg;
	reg done_reg;

	assign por_done_o = done_reg;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= `SCPR_POR_CNT_RESET;
			done_reg <= 1'b0;
		end else if (!done_reg) begin
			cnt_reg <= cnt_reg + 1'b1;
			if (cnt_reg == `SCPR_POR_CYCLES - 1)
				done_reg <= 1'b1;
		end
	end
endmodule // scpr_por

//--- tb/scpr_checker.sv
`timescale 1ns/1ps
module scpr_checker (
	input wire mclk_i,
	input wire nrst_i,
	input wire chip_select_n_i,
	input wire reset_oe_i,
	input wire program_mode_n_i,
	input wire array_valid_i,
	input wire array_req_o,
	input wire [19:0] array_addr_o,
	input wire data_o,
	input wire data_oe_o,
	input wire cascade_enable_out_n_o,
	input wire ready_o,
	input wire ready_oe_o,
	input wire prog_mode_o
);
	// Edges since reset release, saturating
	logic [8:0] up_reg;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			up_reg <= 9'h000;
		else if (up_reg != 9'h1ff)
			up_reg <= up_reg + 9'h001;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	por_window_a: assert property (ready_oe_o == (up_reg < 9'h0fa) && !ready_o)
		else $error("ready window");
	standby_float_a: assert property ((program_mode_n_i && chip_select_n_i) [*3] |-> !data_oe_o)
		else $error("standby drive");
	prog_float_a: assert property (!program_mode_n_i [*3] |-> prog_mode_o && !data_oe_o)
		else $error("prog mode");
	clear_off_a: assert property (!reset_oe_i |=> !data_oe_o && cascade_enable_out_n_o && !array_req_o)
		else $error("clear");
	req_hold_a: assert property (array_req_o && !array_valid_i && reset_oe_i && program_mode_n_i
		|=> array_req_o && $stable(array_addr_o))
		else $error("req hold");
	req_gap_a: assert property (array_req_o && array_valid_i |=> !array_req_o)
		else $error("req gap");
	freeze_data_a: assert property ((chip_select_n_i && reset_oe_i) [*4] |-> $stable(data_o))
		else $error("frozen data");
	done_float_a: assert property ($fell(cascade_enable_out_n_o) |-> !data_oe_o)
		else $error("cascade drive");
endmodule // scpr_checker
bind scpr_top scpr_checker u_chk (.mclk_i, .nrst_i, .chip_select_n_i, .reset_oe_i, .program_mode_n_i,
	.array_valid_i, .array_req_o, .array_addr_o, .data_o, .data_oe_o, .cascade_enable_out_n_o, .ready_o,
	.ready_oe_o, .prog_mode_o);

//--- tb/scpr_fpga_model.sv
`timescale 1ns/1ps
module scpr_fpga_model (
	input wire mclk_i,
	input wire data_i,
	input wire data_oe_i,
	output logic fpga_config_clock_o
);
	initial fpga_config_clock_o = 1'b0;
	// Four mclk high, four low: about 31 MHz, under the read-out ceiling
	task automatic clk_bit(output logic b);
		b = data_oe_i ? data_i : 1'b1; // Released line reads the pull-up
		fpga_config_clock_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		fpga_config_clock_o = 1'b0;
		repeat (4) @(negedge mclk_i);
	endtask
endmodule // scpr_fpga_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
	logic mclk_i = 1'b0, nrst_i = 1'b0, cs_n = 1'b1, roe = 1'b0, pen = 1'b0, vld = 1'b0, hold = 1'b0, b;
	logic pgm_n = 1'b1;
	logic [1:0] pick = 2'h0;
	logic [2:0] lat = 3'h0;
	logic [15:0] word = 16'h0000;
	logic [19:0] base = 20'h00000;
	wire [19:0] addr;
	wire req, dat, oe, casc_n, rdy, rdy_oe, pm, sb, cfg_clk;
	integer seed = 32'h8d793372;
	int bad_count = 0, tests_run = 0, pos = 0, cyc = 0, n = 0;
	scpr_top uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .fpga_config_clock_i(cfg_clk), .chip_select_n_i(cs_n),
		.reset_oe_i(roe), .program_mode_n_i(pgm_n), .paging_enable_i(pen), .partition_pick_i(pick),
		.array_word_i(word), .array_valid_i(vld), .array_req_o(req), .array_addr_o(addr), .data_o(dat),
		.data_oe_o(oe), .cascade_enable_out_n_o(casc_n), .ready_o(rdy), .ready_oe_o(rdy_oe), .prog_mode_o(pm),
		.standby_o(sb));
	scpr_fpga_model fpga (.mclk_i(mclk_i), .data_i(dat), .data_oe_i(oe), .fpga_config_clock_o(cfg_clk));
	initial forever #2 mclk_i = ~mclk_i;
	function automatic [15:0] f(input [19:0] a);
		f = a[15:0] ^ {a[19:16], 12'h6b1};
	endfunction
	// Array answers after a random wait; idle word bus keeps toggling
	always @(negedge mclk_i) begin
		if (req && !vld && !hold && lat == 3'h0) begin
			vld <= 1'b1;
			word <= f(addr);
			lat <= 3'($random(seed));
		end else begin
			vld <= 1'b0;
			word <= ~word;
			if (req && !vld && !hold) lat <= lat - 3'h1;
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic rd(input int k);
		logic [15:0] w;
		repeat (k) begin
			w = f(base + 20'(pos / 16));
			fpga.clk_bit(b);
			`CHK("bit", w[15 - pos % 16], b)
			pos++;
		end
	endtask
	task automatic start(input logic pe, input logic [1:0] pk);
		roe <= 1'b0;
		hold <= 1'b0;
		pen <= pe;
		pick <= pk;
		repeat (3) @(negedge mclk_i);
		base = pe ? {pk, 18'h00000} : 20'h00000;
		pos = 0;
		roe <= 1'b1;
		cs_n <= 1'b0;
		repeat (60) @(negedge mclk_i);
		`CHK("full", 1'b0, req)
		`CHK("oe", 1'b1, oe)
		`CHK("casc_n", 1'b1, casc_n)
	endtask
	initial begin
		repeat (12) @(negedge mclk_i);
		nrst_i <= 1'b1;
		while (rdy_oe === 1'b1 && n < 400) begin
			@(negedge mclk_i);
			n++;
		end
		`CHK("por", 250, n)
		for (int m = 0; m < 5; m++) begin
			start(m != 0, 2'(m - 1));
			rd(20 + ($random(seed) & 31));
			if (m == 2) begin
				cs_n <= 1'b1;
				@(negedge mclk_i);
				repeat (3) fpga.clk_bit(b);
				`CHK("sb", 1'b1, sb)
				`CHK("sb_oe", 1'b0, oe)
				cs_n <= 1'b0;
				repeat (4) @(negedge mclk_i);
				rd(20);
			end
			if (m == 3) begin
				repeat (20) @(negedge mclk_i);
				hold <= 1'b1;
				rd((pos / 16 + 4) * 16 - pos);
				`CHK("refill", 1'b1, req)
			end
		end
		pgm_n <= 1'b0;
		repeat (4) @(negedge mclk_i);
		`CHK("pm", 1'b1, pm)
		`CHK("pm_oe", 1'b0, oe)
		conclude();
	end
endmodule // testbench
